// [ppm_top.sv]
// register core: axi4-lite slave holding the port two and three mode
// registers and driving two pad control instances
// assumes pad inputs are asynchronous and the pad cell resolves its own wire
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "ppm_consts.svh"
module ppm_top #(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  p2_pin_in,
   output logic [7:0]       p2_pin_out,
   output logic [7:0]       p2_pin_oe,
   output logic [7:0]       p2_pullup_en,
   output logic [7:0]       p2_analog_en,
   input  wire logic [7:0]  p3_pin_in,
   output logic [7:0]       p3_pin_out,
   output logic [7:0]       p3_pin_oe,
   output logic [7:0]       p3_pullup_en,
   output logic [7:0]       p3_analog_en
);
   localparam logic [7:0] P2_PRESENT =
      LARGE_PACKAGE ? 8'hFF : `PPM_P2_SMALL_MASK;
   localparam logic [7:0] P3_PRESENT = `PPM_P3_IMPL_MASK;

   ppm_pad_if p2 ();
   ppm_pad_if p3 ();

   ////////////////////////////////////////////////////////////////////////
   // pin input synchronisers, first stage read only by the second
   logic [7:0] p2_meta;
   logic [7:0] p3_meta;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p2_meta        <= 8'h00;
         p3_meta        <= 8'h00;
         p2.pin_sync    <= 8'h00;
         p3.pin_sync    <= 8'h00;
      end else begin
         p2_meta        <= p2_pin_in;
         p3_meta        <= p3_pin_in;
         p2.pin_sync    <= p2_meta;
         p3.pin_sync    <= p3_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   ppm_pkg::ppm_wr_e wr_state;
   logic [7:0]       aw_addr;
   logic             aw_held;
   logic [7:0]       w_data;
   logic             w_strb0;
   logic             w_held;
   logic             wr_fire;
   logic             wr_hit;

   assign wr_fire = aw_held & w_held & (wr_state == ppm_pkg::PPM_WR_IDLE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         aw_addr       <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            // low two bits only pick a byte lane; registers are whole words
            aw_addr <= s_axi_awaddr[9:2];
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end else if (!aw_held && s_axi_awvalid && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held       <= 1'b0;
         w_data       <= 8'h00;
         w_strb0      <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata[7:0];
            w_strb0 <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end else if (!w_held && s_axi_wvalid && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb begin
      if (aw_addr == `PPM_OFS_P2_DRIVE_MODE) wr_hit = 1'b1;
      else if (aw_addr == `PPM_OFS_P3_OUTPUT_LATCH) wr_hit = 1'b1;
      else if (aw_addr == `PPM_OFS_P2_ANALOG_SELECT) wr_hit = 1'b1;
      else if (aw_addr == `PPM_OFS_P3_ANALOG_SELECT) wr_hit = 1'b1;
      else if (aw_addr == `PPM_OFS_P2_OUTPUT_LATCH) wr_hit = 1'b1;
      else if (aw_addr == `PPM_OFS_P3_DRIVE_MODE) wr_hit = 1'b1;
      else if (aw_addr == `PPM_OFS_P2_PIN_STATE) wr_hit = 1'b1;
      else if (aw_addr == `PPM_OFS_P3_PIN_STATE) wr_hit = 1'b1;
      else wr_hit = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state     <= ppm_pkg::PPM_WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         case (wr_state)
            ppm_pkg::PPM_WR_IDLE: begin
               if (wr_fire) begin
                  wr_state     <= ppm_pkg::PPM_WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  // unmapped offsets answer decode error
                  s_axi_bresp  <= wr_hit ? 2'h0 : 2'h3;
               end
            end
            ppm_pkg::PPM_WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state     <= ppm_pkg::PPM_WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: wr_state <= ppm_pkg::PPM_WR_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode registers; pin-state offsets are read only
   logic wr_en;
   assign wr_en = wr_fire & w_strb0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p2.analog_select <= `PPM_RST_ANALOG_SELECT;
         p3.analog_select <= `PPM_RST_ANALOG_SELECT;
         p2.drive_mode    <= `PPM_RST_DRIVE_MODE;
         p3.drive_mode    <= `PPM_RST_DRIVE_MODE;
         p2.output_latch  <= `PPM_RST_OUTPUT_LATCH;
         p3.output_latch  <= `PPM_RST_OUTPUT_LATCH;
      end else if (wr_en) begin
         if (aw_addr == `PPM_OFS_P2_ANALOG_SELECT) begin
            p2.analog_select <= w_data;
         end else if (aw_addr == `PPM_OFS_P3_ANALOG_SELECT) begin
            // only bit 0 exists on port three, the rest read as one
            p3.analog_select <= w_data | ~`PPM_P3_IMPL_MASK;
         end else if (aw_addr == `PPM_OFS_P2_DRIVE_MODE) begin
            p2.drive_mode <= w_data;
         end else if (aw_addr == `PPM_OFS_P3_DRIVE_MODE) begin
            p3.drive_mode <= w_data;
         end else if (aw_addr == `PPM_OFS_P2_OUTPUT_LATCH) begin
            p2.output_latch <= w_data;
         end else if (aw_addr == `PPM_OFS_P3_OUTPUT_LATCH) begin
            p3.output_latch <= w_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel, one cycle to data
   ppm_pkg::ppm_rd_e rd_state;
   logic [7:0]       rd_byte;
   logic             rd_hit;
   logic [7:0]       ar_idx;

   assign ar_idx = s_axi_araddr[9:2];

   always_comb begin
      rd_hit = 1'b1;
      if (ar_idx == `PPM_OFS_P2_DRIVE_MODE) rd_byte = p2.drive_mode;
      else if (ar_idx == `PPM_OFS_P3_OUTPUT_LATCH)
         rd_byte = p3.output_latch;
      else if (ar_idx == `PPM_OFS_P2_ANALOG_SELECT)
         rd_byte = p2.analog_select;
      else if (ar_idx == `PPM_OFS_P3_ANALOG_SELECT)
         rd_byte = p3.analog_select;
      else if (ar_idx == `PPM_OFS_P2_OUTPUT_LATCH)
         rd_byte = p2.output_latch;
      else if (ar_idx == `PPM_OFS_P3_DRIVE_MODE) rd_byte = p3.drive_mode;
      // analog pins read zero
      else if (ar_idx == `PPM_OFS_P2_PIN_STATE) rd_byte = p2.pin_state;
      else if (ar_idx == `PPM_OFS_P3_PIN_STATE) rd_byte = p3.pin_state;
      else begin
         rd_byte = 8'h00;
         rd_hit  = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state      <= ppm_pkg::PPM_RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= 1'b0;
         case (rd_state)
            ppm_pkg::PPM_RD_IDLE: begin
               if (s_axi_arvalid && !s_axi_arready) begin
                  s_axi_arready <= 1'b1;
                  rd_state      <= ppm_pkg::PPM_RD_RESP;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rdata   <= {24'h000000, rd_byte};
                  s_axi_rresp   <= rd_hit ? 2'h0 : 2'h3;
               end
            end
            ppm_pkg::PPM_RD_RESP: begin
               if (s_axi_rready) begin
                  rd_state     <= ppm_pkg::PPM_RD_IDLE;
                  s_axi_rvalid <= 1'b0;
               end
            end
            default: rd_state <= ppm_pkg::PPM_RD_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pad control, outputs registered inside and passed straight out
   ppm_pad_ctl #(.PRESENT(P2_PRESENT)) u_p2 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pad     (p2.pad)
   );
   ppm_pad_ctl #(.PRESENT(P3_PRESENT)) u_p3 (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pad     (p3.pad)
   );

   assign p2_pin_out   = p2.pad_out;
   assign p2_pin_oe    = p2.pad_oe;
   assign p2_pullup_en = p2.pullup_en;
   assign p2_analog_en = p2.analog_en;
   assign p3_pin_out   = p3.pad_out;
   assign p3_pin_oe    = p3.pad_oe;
   assign p3_pullup_en = p3.pullup_en;
   assign p3_analog_en = p3.analog_en;
endmodule

// [ppm_consts.svh]
// constants for the port pin mode block: register indices, resets, widths
// an offset here is a word index: the bus byte address is four times it
// assumes inclusion by bare name from the block's design files
//
// Overview of operation
// - each port-two analog-select bit n sets the mode of pin n, 7 down to 0
// - analog-select bit 0 makes the pin an analog input
// - analog-select bit 1 makes the pin an ordinary digital pin
// - analog pins lose weak pull-up, digital driver and digital receiver
// - drive-mode bit 1 drives the pin push-pull
// - port-two pins 7 to 4 act only on the larger package variant
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

`define PPM_OFS_P2_DRIVE_MODE    8'hA6
`define PPM_OFS_P3_OUTPUT_LATCH  8'hB0
`define PPM_OFS_P2_ANALOG_SELECT 8'hF3
`define PPM_OFS_P3_ANALOG_SELECT 8'hF4
`define PPM_OFS_P2_OUTPUT_LATCH  8'hA0
`define PPM_OFS_P3_DRIVE_MODE    8'hA7
`define PPM_OFS_P2_PIN_STATE     8'hC0
`define PPM_OFS_P3_PIN_STATE     8'hC4

`define PPM_RST_DRIVE_MODE       8'h00
`define PPM_RST_ANALOG_SELECT    8'hFF
`define PPM_RST_OUTPUT_LATCH     8'hFF
`define PPM_P3_IMPL_MASK         8'h01
`define PPM_P2_SMALL_MASK        8'h0F
`define PPM_PORT_W               8

`endif

// [ppm_pkg.sv]
// types for the port pin mode block
// assumes the constants header is available by bare name
package ppm_pkg;
   typedef logic [7:0] ppm_byte_t;
   typedef enum logic [0:0] {
      PPM_WR_IDLE = 1'b0,
      PPM_WR_RESP = 1'b1
   } ppm_wr_e;
   typedef enum logic [0:0] {
      PPM_RD_IDLE = 1'b0,
      PPM_RD_RESP = 1'b1
   } ppm_rd_e;
endpackage

// [ppm_pad_if.sv]
// carrier between the register core and the pad control logic
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface ppm_pad_if;
   logic [7:0] analog_select;
   logic [7:0] drive_mode;
   logic [7:0] output_latch;
   logic [7:0] pin_sync;
   logic [7:0] pin_state;
   logic [7:0] pad_out;
   logic [7:0] pad_oe;
   logic [7:0] pullup_en;
   logic [7:0] analog_en;
   modport core (output analog_select, output drive_mode,
                 output output_latch, output pin_sync,
                 input pin_state, input pad_out, input pad_oe,
                 input pullup_en, input analog_en);
   modport pad  (input analog_select, input drive_mode,
                 input output_latch, input pin_sync,
                 output pin_state, output pad_out, output pad_oe,
                 output pullup_en, output analog_en);
endinterface

// [ppm_pad_ctl.sv]
// per-pin mode logic for one 8-bit port, registered outputs
// assumes pin_sync is already synchronised to aclk
`timescale 1ns/1ns
`include "ppm_consts.svh"
module ppm_pad_ctl #(
   parameter logic [7:0] PRESENT = 8'hFF
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   ppm_pad_if.pad    pad
);
   genvar n;
   generate
      for (n = 0; n < `PPM_PORT_W; n++) begin : g_pin
         wire logic digital;
         // absent pins are held with every output off, analog enable included
         assign digital = pad.analog_select[n] & PRESENT[n];
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pad.pad_out[n]   <= 1'b0;
               pad.pad_oe[n]    <= 1'b0;
               pad.pullup_en[n] <= 1'b0;
               pad.analog_en[n] <= 1'b0;
               pad.pin_state[n] <= 1'b0;
            end else begin
               pad.analog_en[n] <= ~digital & PRESENT[n];
               // analog: pull-up, driver, receiver all off
               pad.pullup_en[n] <= digital & ~pad.drive_mode[n];
               pad.pad_out[n]   <= digital & pad.output_latch[n];
               // push-pull drives both levels, open-drain only low
               pad.pad_oe[n]    <= digital &
                  (pad.drive_mode[n] | ~pad.output_latch[n]);
               pad.pin_state[n] <= digital & pad.pin_sync[n];
            end
         end
      end
   endgenerate
endmodule

// [ppm_top_monitor.sv]
// concurrent checks on the port pin mode block, ports of ppm_top only
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ns
module ppm_monitor #(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [9:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [7:0]  p2_pin_oe,
   input wire logic [7:0]  p2_pullup_en,
   input wire logic [7:0]  p2_analog_en,
   input wire logic [7:0]  p3_pin_oe,
   input wire logic [7:0]  p3_pullup_en,
   input wire logic [7:0]  p3_analog_en
);
   // absent pins never report analog, so the mask follows the package
   localparam logic [7:0] PMASK = LARGE_PACKAGE ? 8'hFF : 8'h0F;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   sequence s_aw_w;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_asel;
      s_aw_w ##0 (s_axi_awaddr == 10'h3CC) && s_axi_wstrb[0];
   endsequence
   property p_aw_pulse;
      s_axi_awready |=> !s_axi_awready;
   endproperty
   property p_b_after;
      s_aw_w |=> ##1 s_axi_bvalid;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_ar_answer;
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
         |=> s_axi_arready && s_axi_rvalid;
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rdata_hi;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   property p_analog_off;
      ((p2_analog_en & (p2_pin_oe | p2_pullup_en)) == 8'h00) &&
      ((p3_analog_en & (p3_pin_oe | p3_pullup_en)) == 8'h00);
   endproperty
   property p_small_pkg;
      !LARGE_PACKAGE |-> {p2_pin_oe[7:4], p2_pullup_en[7:4],
                          p2_analog_en[7:4]} == 12'h000;
   endproperty
   // register lands one edge after the handshake, pads the edge after that
   property p_asel;
      s_wr_asel |=> ##2
         p2_analog_en == (~$past(s_axi_wdata[7:0], 3) & PMASK);
   endproperty
   ////////////////////////////////////////////////////////////////////////
   a_aw_pulse: assert property (p_aw_pulse)
      else $error("awready longer than one cycle");
   a_b_after: assert property (p_b_after)
      else $error("no write response after address and data");
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped before bready");
   a_ar_answer: assert property (p_ar_answer)
      else $error("read not answered one cycle after arvalid");
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped or changed before rready");
   a_rdata_hi: assert property (p_rdata_hi)
      else $error("upper read data bits not zero");
   a_analog_off: assert property (p_analog_off)
      else $error("analog pin still drives or pulls up");
   a_small_pkg: assert property (p_small_pkg)
      else $error("absent pin shows activity");
   a_asel: assert property (p_asel)
      else $error("analog enables do not follow analog select write");
endmodule
bind ppm_top ppm_monitor #(.LARGE_PACKAGE(LARGE_PACKAGE)) u_mon (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .p2_pin_oe(p2_pin_oe), .p2_pullup_en(p2_pullup_en),
   .p2_analog_en(p2_analog_en), .p3_pin_oe(p3_pin_oe),
   .p3_pullup_en(p3_pullup_en), .p3_analog_en(p3_analog_en));

// [ppm_top_tb_top.sv]
// self-checking bench for ppm_top, small package variant
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ns
module ppm_top_tb_top;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
   logic [7:0]  p2_in = 8'h00;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  p2o, p2oe, p2pu, p2an, p3o, p3oe, p3pu, p3an;
   logic [33:0] v;
   int          n_errors = 0, num_checks = 0, cyc = 0;
   always #25 aclk = ~aclk;
   // small package so the absent upper pins are exercised too
   // port three pin 0 shares the port two pin stimulus
   ppm_top #(.LARGE_PACKAGE(1'b0)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .p2_pin_in(p2_in), .p2_pin_out(p2o),
      .p2_pin_oe(p2oe), .p2_pullup_en(p2pu), .p2_analog_en(p2an),
      .p3_pin_in(p2_in), .p3_pin_out(p3o), .p3_pin_oe(p3oe),
      .p3_pullup_en(p3pu), .p3_analog_en(p3an));
   ////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [33:0] s, input logic [33:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // trailing edge keeps a following task off this time step
   task axw(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready === 1'h1)
            awvalid <= 1'h0;
         if (wready === 1'h1)
            wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk(34'(bresp), 34'(r));
      @(posedge aclk);
   endtask
   task axr(input logic [9:0] a, output logic [33:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready === 1'h1)
            arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      r = {rresp, rdata};
      rready <= 1'h0;
      @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      axr(10'h298, v);
      chk(v, 34'h000000000);
      axr(10'h2C0, v);
      chk(v, 34'h0000000FF);
      axr(10'h3D0, v);
      chk(v, 34'h0000000FF);
      axr(10'h3CC, v);
      chk(v & 34'h00000000F, 34'h00000000F);
      chk(34'({p2an, p2oe, p2pu}), 34'h00000F);
   endtask
   task t_modes;
      logic [7:0] an, dig;
      // pin0 push-pull high, pin1 open-drain high, 2 and 3 driven low
      axw(10'h298, 32'h05, 2'h0);
      axw(10'h280, 32'h03, 2'h0);
      for (int i = 0; i < 8; i++) begin
         an = 8'h01 << i;
         dig = ~an & 8'h0F;
         axw(10'h3CC, 32'(~an), 2'h0);
         chk(34'(p2an), 34'(an & 8'h0F));
         chk(34'(p2oe), 34'(dig & 8'h0D));
         chk(34'(p2pu), 34'(dig & 8'h0A));
         chk(34'(p2o & p2oe), 34'(dig & 8'h01));
      end
   endtask
   task t_port3;
      axw(10'h3D0, 32'h00, 2'h0);
      chk(34'({p3an[0], p3oe[0], p3pu[0], p3o[0]}), 34'h8);
      axr(10'h3D0, v);
      chk(v, 34'h0000000FE);
      axw(10'h3D0, 32'h01, 2'h0);
      chk(34'({p3an[0], p3oe[0], p3pu[0], p3o[0]}), 34'h3);
      axw(10'h2C0, 32'h00, 2'h0);
      chk(34'({p3an[0], p3oe[0], p3pu[0], p3o[0]}), 34'h6);
      axr(10'h2C0, v);
      chk(v, 34'h000000000);
      // port three push-pull: driver on for both levels, no pull-up
      axw(10'h29C, 32'h01, 2'h0);
      chk(34'({p3an[0], p3oe[0], p3pu[0], p3o[0]}), 34'h4);
      axw(10'h2C0, 32'h01, 2'h0);
      chk(34'({p3an, p3oe, p3pu, p3o}), 34'h00010001);
   endtask
   task t_bus;
      p2_in <= 8'hFF;
      axw(10'h040, 32'h01, 2'h3);
      axr(10'h040, v);
      chk(34'(v[33:32]), 34'h3);
      axw(10'h3CC, 32'h0C, 2'h0);
      axw(10'h300, 32'h00, 2'h0);
      axr(10'h300, v);
      chk(v & 34'h30000000F, 34'h00000000C);
      axr(10'h310, v);
      chk(v, 34'h000000001);
      // byte lane 0 off: answered okay, register untouched
      wstrb <= 4'h0;
      axw(10'h3CC, 32'hFF, 2'h0);
      wstrb <= 4'hF;
      chk(34'(p2an), 34'h03);
      axr(10'h3CC, v);
      chk(v, 34'h00000000C);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_modes();
      t_port3();
      t_bus();
      conclude();
   end
endmodule
